// File: hw/uiopm_pkg.sv
package uiopm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are not byte addresses: they are indices, byte = 4 * index
  localparam logic [7:0]  UIOPM_IDX_WRITE   = 8'h39;
  localparam logic [7:0]  UIOPM_IDX_SET     = 8'h3a;
  localparam logic [7:0]  UIOPM_IDX_CLEAR   = 8'h3b;
  localparam logic [7:0]  UIOPM_IDX_MODE    = 8'h3c;
  localparam logic [7:0]  UIOPM_IDX_OUT     = 8'h3d;
  localparam int          UIOPM_ADDR_W      = 10;

  // ----------------------------------------------------------------
  // Field layout and reset
  // ----------------------------------------------------------------
  localparam int          UIOPM_SWAP_BIT    = 1;
  localparam int          UIOPM_SER_LO      = 2;
  localparam int          UIOPM_PUP_POS_BIT = 4;
  localparam int          UIOPM_PUP_NEG_BIT = 5;
  localparam int          UIOPM_NRM_LO      = 6;
  localparam logic [7:0]  UIOPM_RESET_VAL   = 8'h04;
  localparam logic [7:0]  UIOPM_WRITE_MASK  = 8'hfe;

  // ----------------------------------------------------------------
  // Regulator level codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  UIOPM_LVL_3V3     = 2'h0;

  // Mode register fields
  localparam int          UIOPM_MODE_SER    = 0;
  localparam int          UIOPM_MODE_AUD    = 1;
  localparam int          UIOPM_MODE_TXEN   = 2;

  // AXI responses
  localparam logic [1:0]  UIOPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  UIOPM_RESP_SLVERR = 2'h2;

endpackage

// File: hw/uiopm_axil_slave.sv
`timescale 1ns/1ns
// Minimal AXI4-Lite slave: takes AW and W in any order, one write and one read at a time
module uiopm_axil_slave
  import uiopm_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // Write channels
  input  wire logic [UIOPM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output wire logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output wire logic                    s_axi_wready,
  output logic      [1:0]              s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // Read channels
  input  wire logic [UIOPM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output wire logic                    s_axi_arready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Register side
  output wire logic                    wr_stb,
  output logic      [7:0]              wr_idx_ff,
  output logic      [7:0]              wr_data_ff,
  input  wire logic                    wr_ok,
  output wire logic [7:0]              rd_idx,
  input  wire logic [7:0]              rd_data,
  input  wire logic                    rd_ok
);

  logic aw_ff;
  logic w_ff;
  logic wlane_ff;

  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_ff && !s_axi_bvalid;
  assign wr_stb        = aw_ff && w_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[UIOPM_ADDR_W-1:2];

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      wlane_ff     <= 1'b0;
      wr_idx_ff    <= 8'h00;
      wr_data_ff   <= 8'h00;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= UIOPM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff     <= 1'b1;
        wr_idx_ff <= s_axi_awaddr[UIOPM_ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ff       <= 1'b1;
        wr_data_ff <= s_axi_wdata[7:0];
        wlane_ff   <= s_axi_wstrb[0];
      end
      if (wr_stb)
      begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? UIOPM_RESP_OKAY : UIOPM_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= UIOPM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_data};
      s_axi_rresp  <= rd_ok ? UIOPM_RESP_OKAY : UIOPM_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // The lane 0 byte strobe is kept but not acted on: a write always takes the low data byte
  wire unused_lane = wlane_ff;

endmodule

// File: hw/uiopm_reg.sv
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
// Behaviour
// [R1] Write, set, clear addresses; all three read
// [R2] Swap bit exchanges positive and negative lines
// [R3] Serial mode routing also follows swap
// [R4] Audio speaker pins ignore swap
// [R5] Serial level field bits 3:2, reset 01
// [R6] Entering serial with transmit enable applies field
// [R7] Audio mode holds regulator at 3.3V
// [R8] Link leaves serial mode via reset pin
// [R9] Pull-up enables; forced on in serial mode
// [R10] Normal modes use level field bits 7:6
// [R11] Normal level encoding, default 3.3V
// [R12] Set/clear touch ones only; bit 0 zero
module uiopm_reg
  import uiopm_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  // AXI4-Lite slave
  input  wire logic [UIOPM_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output wire logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output wire logic                    s_axi_wready,
  output wire logic [1:0]              s_axi_bresp,
  output wire logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [UIOPM_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output wire logic                    s_axi_arready,
  output wire logic [31:0]             s_axi_rdata,
  output wire logic [1:0]              s_axi_rresp,
  output wire logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Operating mode, same clock domain
  input  wire logic                    serial_mode,
  input  wire logic                    audio_mode,
  input  wire logic                    serial_transmit_enable,
  // Transceiver line functions
  input  wire logic                    xcvr_pos_out,
  input  wire logic                    xcvr_neg_out,
  input  wire logic                    ser_tx,
  input  wire logic                    spk_left_in,
  input  wire logic                    spk_right_in,
  output logic                         line_pos_ff,
  output logic                         line_neg_ff,
  output logic                         speaker_left_pin_ff,
  output logic                         speaker_right_pin_ff,
  // Regulator and pull-ups
  output logic      [1:0]              regulated_3v3_output_ff,
  output logic                         charger_pullup_pos_en_ff,
  output logic                         charger_pullup_neg_en_ff
);

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  wire logic       wr_stb;
  wire logic [7:0] wr_idx;
  wire logic [7:0] wr_data;
  wire logic [7:0] rd_idx;
  wire logic       wr_ok;
  wire logic       rd_ok;
  wire logic [7:0] rd_data;

  uiopm_axil_slave u_slave (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_idx_ff     (wr_idx),
    .wr_data_ff    (wr_data),
    .wr_ok         (wr_ok),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic       serial_d_ff;

  // [R1] address decode
  wire logic hit_wr  = (wr_idx == UIOPM_IDX_WRITE);
  wire logic hit_set = (wr_idx == UIOPM_IDX_SET);
  wire logic hit_clr = (wr_idx == UIOPM_IDX_CLEAR);
  assign wr_ok = hit_wr || hit_set || hit_clr;

  // [R12] one-only set and clear
  wire logic [7:0] wmask    = wr_data & UIOPM_WRITE_MASK;
  wire logic [7:0] nxt_ctrl = hit_wr  ? wmask :
                              hit_set ? (ctrl_ff | wmask) :
                              hit_clr ? (ctrl_ff & ~wmask) : ctrl_ff;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ctrl_ff <= UIOPM_RESET_VAL;
    else if (wr_stb)
      ctrl_ff <= nxt_ctrl;
  end

  wire logic       swap    = ctrl_ff[UIOPM_SWAP_BIT];
  // [R5] serial level field
  wire logic [1:0] ser_lvl = ctrl_ff[UIOPM_SER_LO+:2];
  // [R11] normal level field
  wire logic [1:0] nrm_lvl = ctrl_ff[UIOPM_NRM_LO+:2];

  // ------------------------------------------------------------------
  // Readback
  // ------------------------------------------------------------------
  // [R1] all three addresses read the same contents
  wire logic rd_ctrl = (rd_idx == UIOPM_IDX_WRITE) || (rd_idx == UIOPM_IDX_SET) ||
                       (rd_idx == UIOPM_IDX_CLEAR);
  wire logic rd_mode = (rd_idx == UIOPM_IDX_MODE);
  wire logic rd_out  = (rd_idx == UIOPM_IDX_OUT);
  assign rd_ok   = rd_ctrl || rd_mode || rd_out;
  assign rd_data = rd_ctrl ? ctrl_ff :
                   rd_mode ? {5'h00, serial_transmit_enable, audio_mode, serial_mode} :
                   rd_out  ? {4'h0, charger_pullup_neg_en_ff, charger_pullup_pos_en_ff,
                              regulated_3v3_output_ff} : 8'h00;

  // ------------------------------------------------------------------
  // Regulator level
  // ------------------------------------------------------------------
  // Serial level latched whenever transmit enable is high in serial mode; until then the
  // normal level stays, which is why the link should leave via reset.
  logic       ser_applied_ff;
  wire logic  ser_entry = serial_mode && !serial_d_ff;
  // [R6] transmit enable at entry or later in serial mode
  wire logic  nxt_ser_applied = serial_mode &&
                                (ser_applied_ff || (ser_entry && serial_transmit_enable) ||
                                 serial_transmit_enable);
  // [R7] audio forces 3.3V
  wire logic [1:0] nxt_lvl = audio_mode      ? UIOPM_LVL_3V3 :
                             nxt_ser_applied ? ser_lvl :
                             nrm_lvl;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      serial_d_ff             <= 1'b0;
      ser_applied_ff          <= 1'b0;
      regulated_3v3_output_ff <= UIOPM_LVL_3V3;
    end
    else
    begin
      serial_d_ff             <= serial_mode;
      ser_applied_ff          <= nxt_ser_applied;
      // [R10] normal modes follow bits 7:6
      regulated_3v3_output_ff <= nxt_lvl;
    end
  end

  // ------------------------------------------------------------------
  // Lines and pull-ups
  // ------------------------------------------------------------------
  // [R2] line sources: serial transmit or transceiver, swapped at the flops below
  wire logic src_pos = serial_mode ? ser_tx : xcvr_pos_out;
  wire logic src_neg = serial_mode ? 1'b1 : xcvr_neg_out;
  // [R9] pull-ups forced in serial mode
  wire logic nxt_pup_pos = ctrl_ff[UIOPM_PUP_POS_BIT] || serial_mode;
  wire logic nxt_pup_neg = ctrl_ff[UIOPM_PUP_NEG_BIT] || serial_mode;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      line_pos_ff              <= 1'b0;
      line_neg_ff              <= 1'b0;
      speaker_left_pin_ff      <= 1'b0;
      speaker_right_pin_ff     <= 1'b0;
      charger_pullup_pos_en_ff <= 1'b0;
      charger_pullup_neg_en_ff <= 1'b0;
    end
    else
    begin
      // [R3] serial routing swapped too
      line_pos_ff              <= swap ? src_neg : src_pos;
      line_neg_ff              <= swap ? src_pos : src_neg;
      // [R4] speakers never swap
      speaker_left_pin_ff      <= audio_mode ? spk_left_in : 1'b0;
      speaker_right_pin_ff     <= audio_mode ? spk_right_in : 1'b0;
      charger_pullup_pos_en_ff <= nxt_pup_pos;
      charger_pullup_neg_en_ff <= nxt_pup_neg;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  bit0_zero_a: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    ctrl_ff[0] == 1'b0) else $error("reserved bit set");

  set_only_a: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    wr_stb && hit_set |=> ctrl_ff == ($past(ctrl_ff) | ($past(wr_data) & 8'hfe)))
    else $error("set write wrong");

  clr_only_a: assert property (@(posedge ref_clk) disable iff (srst) // [R12]
    wr_stb && hit_clr |=> ctrl_ff == ($past(ctrl_ff) & ~$past(wr_data)))
    else $error("clear write wrong");

  direct_wr_a: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
    wr_stb && hit_wr |=> ctrl_ff == ($past(wr_data) & 8'hfe))
    else $error("direct write wrong");

  audio_level_a: assert property (@(posedge ref_clk) disable iff (srst) // [R7]
    audio_mode |=> regulated_3v3_output_ff == 2'h0) else $error("audio level not 3v3");

  normal_level_a: assert property (@(posedge ref_clk) disable iff (srst) // [R10]
    !audio_mode && !serial_mode |=> regulated_3v3_output_ff == $past(ctrl_ff[7:6]))
    else $error("normal level wrong");

  serial_level_a: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
    !audio_mode && serial_mode && serial_transmit_enable
    |=> regulated_3v3_output_ff == $past(ctrl_ff[3:2])) else $error("serial level wrong");

  pullup_force_a: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
    serial_mode |=> charger_pullup_pos_en_ff && charger_pullup_neg_en_ff)
    else $error("pull-ups not forced");

  swap_lines_a: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
    !serial_mode && ctrl_ff[1] |=> line_pos_ff == $past(xcvr_neg_out) &&
    line_neg_ff == $past(xcvr_pos_out)) else $error("swap wrong");

  speaker_fixed_a: assert property (@(posedge ref_clk) disable iff (srst) // [R4]
    audio_mode |=> speaker_left_pin_ff == $past(spk_left_in)) else $error("speaker swapped");

  // ------------------------------------------------------------------
  // Reset, bus access, routing, pull-up and serial level checks
  // ------------------------------------------------------------------
  ctrl_reset_a: assert property (@(posedge ref_clk) // [R5]
    srst |=> ctrl_ff == UIOPM_RESET_VAL)
    else $error("control reset wrong");

  level_reset_a: assert property (@(posedge ref_clk) // [R11]
    srst |=> regulated_3v3_output_ff == UIOPM_LVL_3V3 && !charger_pullup_pos_en_ff)
    else $error("level reset wrong");

  bad_write_a: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
    wr_stb && !wr_ok |=> ctrl_ff == $past(ctrl_ff))
    else $error("unmapped write changed register");

  ctrl_read_a: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
    s_axi_arvalid && s_axi_arready && rd_ctrl |=> s_axi_rdata[7:0] == $past(ctrl_ff))
    else $error("readback wrong");

  bad_read_a: assert property (@(posedge ref_clk) disable iff (srst) // [R1]
    s_axi_arvalid && s_axi_arready && !rd_ok |=> s_axi_rresp == UIOPM_RESP_SLVERR)
    else $error("unmapped read not refused");

  straight_lines_a: assert property (@(posedge ref_clk) disable iff (srst) // [R2]
    !serial_mode && !swap |=> line_pos_ff == $past(xcvr_pos_out) &&
    line_neg_ff == $past(xcvr_neg_out)) else $error("lines swapped");

  serial_route_a: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
    serial_mode && swap |=> line_pos_ff && line_neg_ff == $past(ser_tx))
    else $error("serial swap wrong");

  serial_plain_a: assert property (@(posedge ref_clk) disable iff (srst) // [R3]
    serial_mode && !swap |=> line_neg_ff && line_pos_ff == $past(ser_tx))
    else $error("serial routing wrong");

  pullup_bits_a: assert property (@(posedge ref_clk) disable iff (srst) // [R9]
    !serial_mode |=> charger_pullup_pos_en_ff == $past(ctrl_ff[UIOPM_PUP_POS_BIT]) &&
    charger_pullup_neg_en_ff == $past(ctrl_ff[UIOPM_PUP_NEG_BIT]))
    else $error("pull-up bits wrong");

  speaker_right_a: assert property (@(posedge ref_clk) disable iff (srst) // [R4]
    audio_mode |=> speaker_right_pin_ff == $past(spk_right_in))
    else $error("right speaker wrong");

  speaker_mute_a: assert property (@(posedge ref_clk) disable iff (srst) // [R4]
    !audio_mode |=> !speaker_left_pin_ff && !speaker_right_pin_ff)
    else $error("speakers not idle");

  serial_hold_a: assert property (@(posedge ref_clk) disable iff (srst) // [R6]
    serial_mode && ser_applied_ff && !audio_mode |=> regulated_3v3_output_ff == $past(ser_lvl))
    else $error("serial level not held");

endmodule

// File: dv/uiopm_link_model.sv
`timescale 1ns/1ns
// Link controller as bus master: one write and one read at a time
module uiopm_link_model
  import uiopm_pkg::*;
(
  // Clock
  input  wire logic                    ref_clk,
  // Write channels
  output logic      [UIOPM_ADDR_W-1:0] s_axi_awaddr,
  output logic                         s_axi_awvalid,
  input  wire logic                    s_axi_awready,
  output logic      [31:0]             s_axi_wdata,
  output logic      [3:0]              s_axi_wstrb,
  output logic                         s_axi_wvalid,
  input  wire logic                    s_axi_wready,
  input  wire logic                    s_axi_bvalid,
  output logic                         s_axi_bready,
  // Read channels
  output logic      [UIOPM_ADDR_W-1:0] s_axi_araddr,
  output logic                         s_axi_arvalid,
  input  wire logic                    s_axi_arready,
  input  wire logic                    s_axi_rvalid,
  output logic                         s_axi_rready
);
  int tmo = 0;

  initial
  begin
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
  end

  // Each channel is held until its own ready; a bound catches a hung slave
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    s_axi_bready <= 1'b0;
    tmo += int'(n == 64);
  endtask

  task automatic rd(input logic [7:0] idx);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    s_axi_rready <= 1'b0;
    tmo += int'(n == 64);
  endtask
endmodule

// File: dv/usb_io_power_management_reg_tb_top.sv
`timescale 1ns/1ns
module usb_io_power_management_reg_tb_top;
  import uiopm_pkg::*;
  logic                    ref_clk, srst;
  logic [UIOPM_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  logic                    serial_mode, audio_mode, serial_transmit_enable;
  logic                    xcvr_pos_out, xcvr_neg_out, ser_tx, spk_left_in, spk_right_in;
  logic                    line_pos_ff, line_neg_ff, speaker_left_pin_ff, speaker_right_pin_ff;
  logic [1:0]              regulated_3v3_output_ff;
  logic                    charger_pullup_pos_en_ff, charger_pullup_neg_en_ff;
  logic [7:0]              cm, d, x;
  logic [9:0]              got;
  logic [9:0]              exp_q[$];
  int                      fails = 0;
  int                      total_checks = 0;
  wire logic [7:0]         obs = {regulated_3v3_output_ff, charger_pullup_pos_en_ff,
    charger_pullup_neg_en_ff, line_pos_ff, line_neg_ff, speaker_left_pin_ff, speaker_right_pin_ff};

  uiopm_reg u_uiopm_reg (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .serial_mode(serial_mode), .audio_mode(audio_mode),
    .serial_transmit_enable(serial_transmit_enable), .xcvr_pos_out(xcvr_pos_out),
    .xcvr_neg_out(xcvr_neg_out), .ser_tx(ser_tx), .spk_left_in(spk_left_in),
    .spk_right_in(spk_right_in), .line_pos_ff(line_pos_ff), .line_neg_ff(line_neg_ff),
    .speaker_left_pin_ff(speaker_left_pin_ff), .speaker_right_pin_ff(speaker_right_pin_ff),
    .regulated_3v3_output_ff(regulated_3v3_output_ff),
    .charger_pullup_pos_en_ff(charger_pullup_pos_en_ff),
    .charger_pullup_neg_en_ff(charger_pullup_neg_en_ff));

  uiopm_link_model u_link (.ref_clk(ref_clk), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic report(input bit bad, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (bad)
    begin
      fails++;
      $display("[ERR] %0t expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_bus(input logic [9:0] e, input logic [9:0] g);
    report(g !== e, e, g);
  endtask

  task automatic cmp_pins(input logic [7:0] e, input logic [7:0] g);
    report(g !== e, {2'h0, e}, {2'h0, g});
  endtask

  // Audio beats serial; serial routes the transmit line with the negative line idle high
  function automatic logic [7:0] exp_out(input logic [7:0] c);
    logic p;
    logic n;
    p = serial_mode ? ser_tx : xcvr_pos_out;
    n = serial_mode ? 1'b1 : xcvr_neg_out;
    return {audio_mode ? UIOPM_LVL_3V3 : (serial_mode ? c[3:2] : c[7:6]),
      c[4] | serial_mode, c[5] | serial_mode, c[1] ? n : p, c[1] ? p : n,
      audio_mode & spk_left_in, audio_mode & spk_right_in};
  endfunction

  always @(posedge ref_clk)
    if ((s_axi_rvalid & s_axi_rready) === 1'b1 || (s_axi_bvalid & s_axi_bready) === 1'b1)
    begin
      got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata[7:0]} : {s_axi_bresp, 8'h00};
      cmp_bus(exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff, got);
    end

  task automatic rd(input logic [7:0] idx, input logic [9:0] e);
    exp_q.push_back(e);
    u_link.rd(idx);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [1:0] r);
    exp_q.push_back({r, 8'h00});
    u_link.wr(idx, v);
  endtask

  // Outputs settle one cycle after the register or mode moves
  task automatic chk(input logic [7:0] k);
    repeat (3) @(posedge ref_clk);
    cmp_pins(exp_out(cm) & k, obs & k);
  endtask

  task automatic op(input int k, input logic [7:0] v);
    case (k)
      0: cm = v & UIOPM_WRITE_MASK;
      1: cm = cm | (v & UIOPM_WRITE_MASK);
      default: cm = cm & ~v;
    endcase
    wr(UIOPM_IDX_WRITE + 8'(k), v, UIOPM_RESP_OKAY);
    for (int j = 0; j < 3; j++)
      rd(UIOPM_IDX_WRITE + 8'(j), {UIOPM_RESP_OKAY, cm});
  endtask

  task automatic stop_test();
    fails += u_link.tmo;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h8537));
    srst = 1'b1;
    {serial_mode, audio_mode, serial_transmit_enable} = 3'h0;
    {xcvr_pos_out, xcvr_neg_out, ser_tx, spk_left_in, spk_right_in} = 5'h0;
    cm = UIOPM_RESET_VAL;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(UIOPM_IDX_WRITE, {UIOPM_RESP_OKAY, UIOPM_RESET_VAL});
    chk(8'hff);
    // Normal, then audio, then serial with transmit enable
    for (int i = 0; i < 12; i++)
    begin
      d = 8'($urandom);
      d[0] = 1'b1;
      if (i < 4)
        d[7:6] = 2'(i);
      serial_mode <= i > 5;
      serial_transmit_enable <= i > 5;
      audio_mode <= i == 4 || i == 5;
      {xcvr_pos_out, xcvr_neg_out, ser_tx, spk_left_in, spk_right_in} <= 5'($urandom);
      chk(8'hff);
      op(i % 3, d);
      chk(8'hff);
      x = {5'h00, serial_transmit_enable, audio_mode, serial_mode};
      rd(UIOPM_IDX_MODE, {UIOPM_RESP_OKAY, x});
      x = exp_out(cm);
      rd(UIOPM_IDX_OUT, {UIOPM_RESP_OKAY, 4'h0, x[4], x[5], x[7:6]});
    end
    srst <= 1'b1;
    serial_mode <= 1'b0;
    serial_transmit_enable <= 1'b0;
    @(posedge ref_clk);
    srst <= 1'b0;
    cm = UIOPM_RESET_VAL;
    chk(8'hff);
    wr(8'h10, 8'hff, UIOPM_RESP_SLVERR);
    rd(8'h10, {UIOPM_RESP_SLVERR, 8'h00});
    rd(UIOPM_IDX_CLEAR, {UIOPM_RESP_OKAY, cm});
    repeat (2) @(posedge ref_clk);
    stop_test();
  end
endmodule
